// ### logic/cvt_pkg.sv
// Package for the capture vertical timing register bank.
// Assumes an AHB-Lite host and one capture channel on hclk.
package cvt_pkg;
  localparam logic [7:0]  OFS_CFG_A      = 8'h00;
  localparam logic [7:0]  OFS_CFG_B      = 8'h04;
  localparam logic [7:0]  OFS_CFG_C      = 8'h08;
  localparam logic [7:0]  OFS_IMG_SIZE   = 8'h0C;
  localparam logic [7:0]  OFS_CTRL       = 8'h10;
  localparam logic [7:0]  OFS_STATUS     = 8'h14;
  localparam int          HI_LSB         = 16;
  localparam int          LO_LSB         = 0;
  localparam int          POS_W          = 12;
  localparam logic [11:0] POS_RESET      = 12'h000;
  localparam logic [11:0] LINE_FIRST     = 12'h001;
  localparam int          CTRL_INTERLACE = 0;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

  typedef struct packed {
    logic [11:0] top_field_start_marker;
    logic [11:0] second_line_marker;
    logic [11:0] third_line_marker;
    logic [11:0] bottom_field_start_marker;
    logic [11:0] fifth_line_marker;
    logic [11:0] sixth_line_marker;
    logic [11:0] vertical_line_count;
    logic        interlace_select;
  } cvt_cfg_t;

  typedef struct packed {
    logic        line_strobe;
    logic        frame_start;
    logic        field_bottom;
  } cvt_video_t;

  typedef struct packed {
    logic [11:0] line_number;
    logic [11:0] line_index;
    logic [5:0]  marker_hit;
    logic        in_image;
  } cvt_timing_t;

  typedef enum logic [1:0] {
    cvt_wait_frame,
    cvt_top_field,
    cvt_bottom_field
  } cvt_state_t;
endpackage

// ### logic/cvt_top.sv
// Capture vertical timing configuration with a one-based line counter.
// Assumes AHB-Lite single word transfers and video strobes synchronous to hclk.
//
// Function
// [RL1] Line counter starts at one each frame
// [RL2] Written positions reach comparators without shadow
// [RL3] First marker in cfg_a bits 27-16
// [RL4] Second marker in cfg_a bits 11-0
// [RL5] Third marker in cfg_b bits 27-16
// [RL6] Bottom field marker used only when interlaced
// [RL7] Fifth marker honoured only when interlaced
// [RL8] Sixth marker honoured only when interlaced
// [RL9] Image size held in bits 11-0
// [RL10] Software programs image size per frame
// [RL11] Line index subtracts field start marker
// [RL12] Reserved bits read zero, writes ignored
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
module cvt_top
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [7:0]           haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire cvt_pkg::cvt_video_t  video,
  output cvt_pkg::cvt_timing_t      timing
);
  cvt_pkg::cvt_cfg_t   cfg;
  cvt_pkg::cvt_state_t state;
  cvt_pkg::cvt_state_t next_state;
  logic [11:0]         line_cnt;
  logic [11:0]         next_line_cnt;
  logic                wr_pend;
  logic [7:0]          wr_addr;

  function automatic logic [31:0] pack_pair(input logic [11:0] hi, input logic [11:0] lo);
    pack_pair = {4'h0, hi, 4'h0, lo}; // RL12
  endfunction

  function automatic logic [11:0] field12(input logic [31:0] w, input int lsb);
    field12 = w[lsb +: cvt_pkg::POS_W];
  endfunction

  // Bus decode; writes land in the data phase, so no wait states are needed
  wire       addr_phase = hsel && hready && (htrans == cvt_pkg::HTRANS_NONSEQ);
  wire       rd_start   = addr_phase && !hwrite;
  wire [31:0] rd_word   =
    (haddr == cvt_pkg::OFS_CFG_A)    ? pack_pair(cfg.top_field_start_marker, cfg.second_line_marker) :
    (haddr == cvt_pkg::OFS_CFG_B)    ? pack_pair(cfg.third_line_marker, cfg.bottom_field_start_marker) :
    (haddr == cvt_pkg::OFS_CFG_C)    ? pack_pair(cfg.fifth_line_marker, cfg.sixth_line_marker) :
    (haddr == cvt_pkg::OFS_IMG_SIZE) ? {20'h00000, cfg.vertical_line_count} : // RL9 RL12
    (haddr == cvt_pkg::OFS_CTRL)     ? {31'h0000000, cfg.interlace_select} :
    (haddr == cvt_pkg::OFS_STATUS)   ? {state == cvt_pkg::cvt_bottom_field, 3'h0, line_cnt, 4'h0, timing.line_index} :
    32'h00000000;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h00000000;
    end
    else
    begin
      wr_pend <= addr_phase && hwrite;
      wr_addr <= haddr;
      if (rd_start)
        hrdata <= rd_word;
    end
  end

  // Direct write into the live configuration: comparators see it next cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cfg <= '0;
    else if (wr_pend)
    begin
      case (wr_addr)
        cvt_pkg::OFS_CFG_A:
        begin
          cfg.top_field_start_marker <= field12(hwdata, cvt_pkg::HI_LSB); // RL3 RL2
          cfg.second_line_marker     <= field12(hwdata, cvt_pkg::LO_LSB); // RL4
        end
        cvt_pkg::OFS_CFG_B:
        begin
          cfg.third_line_marker         <= field12(hwdata, cvt_pkg::HI_LSB); // RL5
          cfg.bottom_field_start_marker <= field12(hwdata, cvt_pkg::LO_LSB);
        end
        cvt_pkg::OFS_CFG_C:
        begin
          cfg.fifth_line_marker <= field12(hwdata, cvt_pkg::HI_LSB);
          cfg.sixth_line_marker <= field12(hwdata, cvt_pkg::LO_LSB);
        end
        cvt_pkg::OFS_IMG_SIZE: cfg.vertical_line_count <= field12(hwdata, cvt_pkg::LO_LSB); // RL9
        cvt_pkg::OFS_CTRL:     cfg.interlace_select <= hwdata[cvt_pkg::CTRL_INTERLACE];
        default:               cfg <= cfg;
      endcase
    end
  end

  // Field tracking; progressive pictures never enter the bottom field
  wire bottom_hit = cfg.interlace_select && video.field_bottom; // RL6

  always_comb
  begin
    next_state    = state;
    next_line_cnt = line_cnt;
    if (video.frame_start)
    begin
      next_state    = cvt_pkg::cvt_top_field;
      next_line_cnt = cvt_pkg::LINE_FIRST; // RL1
    end
    else if (video.line_strobe)
    begin
      next_line_cnt = line_cnt + 12'h001;
      case (state)
        cvt_pkg::cvt_wait_frame:   next_state = cvt_pkg::cvt_wait_frame;
        cvt_pkg::cvt_top_field:    next_state = bottom_hit ? cvt_pkg::cvt_bottom_field : cvt_pkg::cvt_top_field;
        cvt_pkg::cvt_bottom_field: next_state = cvt_pkg::cvt_bottom_field;
        default:                   next_state = cvt_pkg::cvt_wait_frame;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state    <= cvt_pkg::cvt_wait_frame;
      line_cnt <= cvt_pkg::POS_RESET;
    end
    else
    begin
      state    <= next_state;
      line_cnt <= next_line_cnt;
    end
  end

  wire        ilace   = cfg.interlace_select;
  wire        in_btm  = state == cvt_pkg::cvt_bottom_field;
  wire [11:0] base    = in_btm ? cfg.bottom_field_start_marker : cfg.top_field_start_marker; // RL11
  wire [5:0]  hit_now =
  {
    ilace && (line_cnt == cfg.sixth_line_marker), // RL8
    ilace && (line_cnt == cfg.fifth_line_marker), // RL7
    ilace && (line_cnt == cfg.bottom_field_start_marker), // RL6
    line_cnt == cfg.third_line_marker, // RL5
    line_cnt == cfg.second_line_marker, // RL4
    line_cnt == cfg.top_field_start_marker // RL3
  };
  wire        active  = (state != cvt_pkg::cvt_wait_frame) && (line_cnt <= cfg.vertical_line_count);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timing <= '0;
    else
    begin
      timing.line_number <= line_cnt;
      timing.line_index  <= line_cnt - base; // RL11
      timing.marker_hit  <= (state == cvt_pkg::cvt_wait_frame) ? 6'h00 : hit_now; // RL2
      timing.in_image    <= active;
    end
  end

  chk_count_from_one: // RL1
    assert property (@(posedge hclk) disable iff (!hresetn) video.frame_start |=> line_cnt == 12'h001)
    else $error("line counter did not restart at one");
  chk_direct_cfg_a: // RL2
    assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend && wr_addr == cvt_pkg::OFS_CFG_A |=> cfg.top_field_start_marker == $past(hwdata[27:16]))
    else $error("cfg_a write not applied next cycle");
  chk_cfg_a_low: // RL4
    assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend && wr_addr == cvt_pkg::OFS_CFG_A |=> cfg.second_line_marker == $past(hwdata[11:0]))
    else $error("second marker not stored");
  chk_cfg_b_high: // RL5
    assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend && wr_addr == cvt_pkg::OFS_CFG_B |=> cfg.third_line_marker == $past(hwdata[27:16]))
    else $error("third marker not stored");
  chk_progressive_no_btm: // RL6
    assert property (@(posedge hclk) disable iff (!hresetn) !cfg.interlace_select |=> !timing.marker_hit[3])
    else $error("bottom marker hit in progressive mode");
  chk_fifth_gated: // RL7
    assert property (@(posedge hclk) disable iff (!hresetn) !cfg.interlace_select |=> !timing.marker_hit[4])
    else $error("fifth marker hit in progressive mode");
  chk_sixth_gated: // RL8
    assert property (@(posedge hclk) disable iff (!hresetn) !cfg.interlace_select |=> !timing.marker_hit[5])
    else $error("sixth marker hit in progressive mode");
  chk_size_readback: // RL9
    assert property (@(posedge hclk) disable iff (!hresetn)
      rd_start && haddr == cvt_pkg::OFS_IMG_SIZE |=> hrdata == {20'h00000, $past(cfg.vertical_line_count)})
    else $error("image size read back wrong");
  chk_top_index: // RL11
    assert property (@(posedge hclk) disable iff (!hresetn)
      state == cvt_pkg::cvt_top_field |=> timing.line_index == $past(line_cnt) - $past(cfg.top_field_start_marker))
    else $error("top field line index wrong");
  chk_reserved_zero: // RL12
    assert property (@(posedge hclk) disable iff (!hresetn)
      rd_start && haddr == cvt_pkg::OFS_CFG_C |=> hrdata[31:28] == 4'h0 && hrdata[15:12] == 4'h0)
    else $error("reserved bits not zero");

  // Storage of the remaining fields; only a write may move the live copy
  chk_cfg_b_low: // RL6
    assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend && wr_addr == cvt_pkg::OFS_CFG_B |=> cfg.bottom_field_start_marker == $past(hwdata[11:0]))
    else $error("bottom marker not stored");
  chk_cfg_c_high: // RL7
    assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend && wr_addr == cvt_pkg::OFS_CFG_C |=> cfg.fifth_line_marker == $past(hwdata[27:16]))
    else $error("fifth marker not stored");
  chk_cfg_c_low: // RL8
    assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend && wr_addr == cvt_pkg::OFS_CFG_C |=> cfg.sixth_line_marker == $past(hwdata[11:0]))
    else $error("sixth marker not stored");
  chk_size_write: // RL9
    assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend && wr_addr == cvt_pkg::OFS_IMG_SIZE |=> cfg.vertical_line_count == $past(hwdata[11:0]))
    else $error("image size not stored");
  chk_cfg_hold: // RL12
    assert property (@(posedge hclk) disable iff (!hresetn) !wr_pend |=> $stable(cfg))
    else $error("configuration changed without a write");
  chk_reserved_cfg_a: // RL12
    assert property (@(posedge hclk) disable iff (!hresetn)
      rd_start && haddr == cvt_pkg::OFS_CFG_A |=> hrdata[31:28] == 4'h0 && hrdata[15:12] == 4'h0)
    else $error("cfg_a reserved bits not zero");
  chk_reserved_cfg_b: // RL12
    assert property (@(posedge hclk) disable iff (!hresetn)
      rd_start && haddr == cvt_pkg::OFS_CFG_B |=> hrdata[31:28] == 4'h0 && hrdata[15:12] == 4'h0)
    else $error("cfg_b reserved bits not zero");

  // Counter and field tracking
  chk_frame_top: // RL1
    assert property (@(posedge hclk) disable iff (!hresetn) video.frame_start |=> state == cvt_pkg::cvt_top_field)
    else $error("frame start did not enter the top field");
  chk_line_step: // RL1
    assert property (@(posedge hclk) disable iff (!hresetn)
      video.line_strobe && !video.frame_start |=> line_cnt == $past(line_cnt) + 12'h001)
    else $error("line counter did not advance by one");
  chk_status_line: // RL1
    assert property (@(posedge hclk) disable iff (!hresetn)
      rd_start && haddr == cvt_pkg::OFS_STATUS |=> hrdata[27:16] == $past(line_cnt))
    else $error("status line number wrong");
  chk_progressive_top: // RL6
    assert property (@(posedge hclk) disable iff (!hresetn)
      !cfg.interlace_select && state == cvt_pkg::cvt_top_field |=> state != cvt_pkg::cvt_bottom_field)
    else $error("progressive picture entered the bottom field");
  chk_btm_index: // RL11
    assert property (@(posedge hclk) disable iff (!hresetn)
      state == cvt_pkg::cvt_bottom_field |=>
        timing.line_index == $past(line_cnt) - $past(cfg.bottom_field_start_marker))
    else $error("bottom field line index wrong");

  // Marker and image size comparators, the interlaced-only markers gated by the mode
  chk_top_hit: // RL3
    assert property (@(posedge hclk) disable iff (!hresetn)
      state != cvt_pkg::cvt_wait_frame && line_cnt == cfg.top_field_start_marker |=> timing.marker_hit[0])
    else $error("first marker missed");
  chk_second_hit: // RL4
    assert property (@(posedge hclk) disable iff (!hresetn)
      state != cvt_pkg::cvt_wait_frame && line_cnt == cfg.second_line_marker |=> timing.marker_hit[1])
    else $error("second marker missed");
  chk_third_hit: // RL5
    assert property (@(posedge hclk) disable iff (!hresetn)
      state != cvt_pkg::cvt_wait_frame && line_cnt == cfg.third_line_marker |=> timing.marker_hit[2])
    else $error("third marker missed");
  chk_btm_hit: // RL6
    assert property (@(posedge hclk) disable iff (!hresetn)
      ilace && state != cvt_pkg::cvt_wait_frame && line_cnt == cfg.bottom_field_start_marker
        |=> timing.marker_hit[3])
    else $error("bottom marker missed when interlaced");
  chk_fifth_hit: // RL7
    assert property (@(posedge hclk) disable iff (!hresetn)
      ilace && state != cvt_pkg::cvt_wait_frame && line_cnt == cfg.fifth_line_marker |=> timing.marker_hit[4])
    else $error("fifth marker missed when interlaced");
  chk_sixth_hit: // RL8
    assert property (@(posedge hclk) disable iff (!hresetn)
      ilace && state != cvt_pkg::cvt_wait_frame && line_cnt == cfg.sixth_line_marker |=> timing.marker_hit[5])
    else $error("sixth marker missed when interlaced");
  chk_idle_quiet: // RL1
    assert property (@(posedge hclk) disable iff (!hresetn)
      state == cvt_pkg::cvt_wait_frame |=> timing.marker_hit == 6'h00)
    else $error("marker hit before any frame start");
  chk_image_in: // RL9
    assert property (@(posedge hclk) disable iff (!hresetn)
      state != cvt_pkg::cvt_wait_frame && line_cnt <= cfg.vertical_line_count |=> timing.in_image)
    else $error("line inside the image not flagged");
  chk_image_out: // RL9
    assert property (@(posedge hclk) disable iff (!hresetn)
      line_cnt > cfg.vertical_line_count |=> !timing.in_image)
    else $error("line beyond the image flagged");

  cov_bottom_field: cover property (@(posedge hclk) disable iff (!hresetn) state == cvt_pkg::cvt_bottom_field);
  cov_first_hit:    cover property (@(posedge hclk) disable iff (!hresetn) timing.marker_hit[0]);
  cov_cfg_write:    cover property (@(posedge hclk) disable iff (!hresetn) wr_pend);
  cov_bottom_hit:   cover property (@(posedge hclk) disable iff (!hresetn) timing.marker_hit[3]);
  cov_past_image:   cover property (@(posedge hclk) disable iff (!hresetn) line_cnt > cfg.vertical_line_count);
endmodule

// ### verification/capture_vertical_timing_cfg_test.sv
// Self-checking bench for the vertical timing register bank.
// Assumes a zero-wait AHB-Lite slave and the video source model.
`timescale 1ns/1ns
module capture_vertical_timing_cfg_test;
  logic                 hclk, hresetn, hsel, hwrite, rd_due, hit_due;
  logic [7:0]           haddr;
  logic [1:0]           htrans;
  logic [2:0]           hsize;
  logic [31:0]          hwdata, hrdata, seed;
  logic                 hreadyout, hresp;
  cvt_pkg::cvt_video_t  video;
  cvt_pkg::cvt_timing_t timing;
  logic [31:0]          exp_q[$];
  int                   n_errors, compares;
  cvt_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .video(video), .timing(timing));
  cvt_video_src src_u (.hclk(hclk), .video(video));
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
  endfunction
  task cmp(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %0t exp %h got %h", $time, e, g);
    end
  endtask
  task final_report;
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Address phase held until hready, then data phase until hready again
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    haddr  <= a;
    hwrite <= w;
    htrans <= cvt_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_due <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_due <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(a, 1'b0, 32'h0);
  endtask
  task hit(input logic [11:0] ln, input logic img, input logic [5:0] e);
    exp_q.push_back({13'h0, ln, img, e});
    @(posedge hclk);
    hit_due <= 1'b1;
    @(posedge hclk);
    hit_due <= 1'b0;
  endtask
  always @(posedge hclk)
  begin
    if (rd_due === 1'b1)
    begin
      cmp(exp_q.pop_front(), hrdata);
      cmp(32'h00000000, {31'h0000000, hresp});
    end
    if (hit_due === 1'b1)
      cmp(exp_q.pop_front(), {13'h0, timing.line_number, timing.in_image, timing.marker_hit});
  end
  initial
  begin
    #40000;
    n_errors++;
    final_report();
  end
  initial
  begin
    {hsel, hwrite, rd_due, hit_due, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    hresetn = 1'b0;
    seed = 32'h00012E92;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 32'h0);
    for (int i = 0; i < 4; i++) xfer(8'(i * 4), 1'b1, 32'hFFFFFFFF);
    for (int i = 0; i < 3; i++) rd(8'(i * 4), 32'h0FFF0FFF);
    rd(cvt_pkg::OFS_IMG_SIZE, 32'h00000FFF);
    xfer(8'h18, 1'b1, 32'hFFFFFFFF);
    rd(8'h18, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      xfer(cvt_pkg::OFS_CFG_A, 1'b1, seed);
      rd(cvt_pkg::OFS_CFG_A, seed & 32'h0FFF0FFF);
    end
    xfer(cvt_pkg::OFS_CFG_A, 1'b1, 32'h00020004);
    xfer(cvt_pkg::OFS_CFG_B, 1'b1, 32'h00040003);
    xfer(cvt_pkg::OFS_CFG_C, 1'b1, 32'h00040004);
    xfer(cvt_pkg::OFS_IMG_SIZE, 1'b1, 32'h000001E0);
    xfer(cvt_pkg::OFS_CTRL, 1'b1, 32'h0);
    src_u.frame();
    rd(cvt_pkg::OFS_STATUS, 32'h00010FFF);
    src_u.lines(3, 1'b1);
    rd(cvt_pkg::OFS_STATUS, 32'h00040002);
    hit(12'h004, 1'b1, 6'h06);
    xfer(cvt_pkg::OFS_CTRL, 1'b1, 32'h1);
    src_u.frame();
    src_u.lines(2, 1'b0);
    rd(cvt_pkg::OFS_STATUS, 32'h00030001);
    hit(12'h003, 1'b1, 6'h08);
    src_u.lines(1, 1'b1);
    rd(cvt_pkg::OFS_STATUS, 32'h80040001);
    hit(12'h004, 1'b1, 6'h36);
    xfer(cvt_pkg::OFS_CFG_A, 1'b1, 32'h00040004);
    hit(12'h004, 1'b1, 6'h37);
    xfer(cvt_pkg::OFS_IMG_SIZE, 1'b1, 32'h00000003);
    hit(12'h004, 1'b0, 6'h37);
    final_report();
  end
endmodule

// ### verification/cvt_video_src.sv
// Model of the external video source feeding the capture port.
// Assumes strobes are sampled on hclk rising edges.
`timescale 1ns/1ns
module cvt_video_src
(
  input  wire logic           hclk,
  output cvt_pkg::cvt_video_t video
);
  initial video = '0;
  task frame;
    @(posedge hclk);
    video.frame_start <= 1'b1;
    @(posedge hclk);
    video.frame_start <= 1'b0;
  endtask
  // Strobes are spaced by one idle cycle, the slowest legal rate is not needed here
  task lines(input int n, input logic bot);
    repeat (n)
    begin
      @(posedge hclk);
      video.line_strobe  <= 1'b1;
      video.field_bottom <= bot;
      @(posedge hclk);
      video.line_strobe  <= 1'b0;
    end
  endtask
endmodule
